// ===== cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
   input wire logic clk_in,
   input wire logic irq_in,
   input wire logic [15:0] upper_in,
   input wire logic [1:0] want_in,
   output logic [1:0] level_out,
   output logic [15:0] fetch_out
);
   assign level_out = want_in;
   always_ff @(posedge clk_in)
      if (irq_in) fetch_out <= upper_in;
endmodule // cpu_model

// ===== interrupt_vector_priority_map.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] timer0 low half drives line 5, FFF0/FFF1
// [R2] timer0 high half drives line 6, FFEE/FFEF
// [R3] timer1 high half drives line 14, FFDE/FFDF
// [R4] timer1 low half drives line 22, FFCE/FFCF
// [R5] pulsegen1 low half drives line 9, FFE8/FFE9
// [R6] pulsegen1 high half drives line 10, FFE6/FFE7
// [R7] pulsegen0 high half drives line 12, FFE2/FFE3
// [R8] pulsegen0 low half drives line 13, FFE0/FFE1
// [R9] equal levels: lowest line number wins
// [R10] ext n, n+4 share line n; 11,17,21 idle
// [R11] forward only when level outranks cpu level
module interrupt_vector_priority_map (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] ext_req_in,
   input wire logic uart_sio_req_in,
   input wire logic timer0_low_req_in,
   input wire logic timer0_high_req_in,
   input wire logic lin_rx_req_in,
   input wire logic lin_tx_req_in,
   input wire logic pulsegen1_low_req_in,
   input wire logic pulsegen1_high_req_in,
   input wire logic pulsegen0_high_req_in,
   input wire logic pulsegen0_low_req_in,
   input wire logic timer1_high_req_in,
   input wire logic pulse16_req_in,
   input wire logic twowire_req_in,
   input wire logic converter_req_in,
   input wire logic timebase_req_in,
   input wire logic watch_req_in,
   input wire logic timer1_low_req_in,
   input wire logic flash_req_in,
   input wire logic [47:0] level_fields_in,
   input wire logic [1:0] cpu_level_in,
   output logic [23:0] line_req_out,
   output logic irq_out,
   output logic [4:0] irq_line_out,
   output logic [1:0] irq_level_out,
   output logic [15:0] vector_upper_addr_out,
   output logic [15:0] vector_lower_addr_out
);
   // level fields arrive as a plain port; no address decode lives here
   logic [23:0] lines;
   logic [3:0] ext_lines;
   logic [23:0] eligible;
   logic [47:0] level_reg;
   logic [1:0] cpu_level_reg;
   logic [4:0] win_line;
   logic [1:0] win_level;
   logic [1:0] level_field_timer0_low;
   logic [1:0] level_field_timer0_high;
   logic [1:0] level_field_timer1_high;
   logic [1:0] level_field_timer1_low;
   logic [1:0] level_field_pulsegen1_low;
   logic [1:0] level_field_pulsegen1_high;
   logic [1:0] level_field_pulsegen0_high;
   logic [1:0] level_field_pulsegen0_low;

   // 2-bit level of one line out of the packed 48-bit field vector
   function automatic logic [1:0] level_of(input logic [47:0] fields, input logic [4:0] line);
      int unsigned base;
      base = 32'(line) << 1;
      level_of = fields[base +: 2];
   endfunction

   function automatic logic [15:0] upper_addr(input logic [4:0] line);
      logic [15:0] offset;
      offset = 16'(line) * irq_map_pkg::vector_step;
      upper_addr = irq_map_pkg::vector_base - offset;
   endfunction

   // lower byte always sits at the odd address right after the upper one
   function automatic logic [15:0] lower_addr(input logic [4:0] line);
      lower_addr = upper_addr(line) + 16'h0001;
   endfunction

   // external channels n and n+4 fold onto one line
   for (genvar n = 0; n < 4; n++) begin : g_ext_fold
      assign ext_lines[n] = ext_req_in[n] | ext_req_in[n + 4]; // [R10]
   end

   // source-to-line mapping; unused lines tie low
   always_comb begin
      lines = 24'h00_0000;
      lines[3:0] = ext_lines; // [R10]
      lines[irq_map_pkg::line_uart_sio] = uart_sio_req_in; // [R10]
      lines[irq_map_pkg::line_timer0_low] = timer0_low_req_in; // [R1]
      lines[irq_map_pkg::line_timer0_high] = timer0_high_req_in; // [R2]
      lines[irq_map_pkg::line_lin_rx] = lin_rx_req_in;
      lines[irq_map_pkg::line_lin_tx] = lin_tx_req_in;
      lines[irq_map_pkg::line_pulsegen1_low] = pulsegen1_low_req_in; // [R5]
      lines[irq_map_pkg::line_pulsegen1_high] = pulsegen1_high_req_in; // [R6]
      lines[irq_map_pkg::line_pulsegen0_high] = pulsegen0_high_req_in; // [R7]
      lines[irq_map_pkg::line_pulsegen0_low] = pulsegen0_low_req_in; // [R8]
      lines[irq_map_pkg::line_timer1_high] = timer1_high_req_in; // [R3]
      lines[irq_map_pkg::line_pulse16] = pulse16_req_in;
      lines[irq_map_pkg::line_twowire] = twowire_req_in;
      lines[irq_map_pkg::line_converter] = converter_req_in;
      lines[irq_map_pkg::line_timebase] = timebase_req_in;
      lines[irq_map_pkg::line_watch] = watch_req_in;
      lines[irq_map_pkg::line_timer1_low] = timer1_low_req_in; // [R4]
      lines[irq_map_pkg::line_flash] = flash_req_in;
      lines[irq_map_pkg::line_unused_a] = 1'b0; // [R10]
      lines[irq_map_pkg::line_unused_b] = 1'b0; // [R10]
      lines[irq_map_pkg::line_unused_c] = 1'b0; // [R10]
   end

   // level fields registered so priority sees a stable snapshot each cycle
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         level_reg <= {24{irq_map_pkg::level_reset}};
      end else begin
         level_reg <= level_fields_in;
      end
   end

   // cpu level takes the same one-cycle delay as the fields
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cpu_level_reg <= irq_map_pkg::cpu_level_reset;
      end else begin
         cpu_level_reg <= cpu_level_in;
      end
   end

   // named views of the timer and pulse generator level fields
   assign level_field_timer0_low = level_of(level_reg, irq_map_pkg::line_timer0_low);
   assign level_field_timer0_high = level_of(level_reg, irq_map_pkg::line_timer0_high);
   assign level_field_timer1_high = level_of(level_reg, irq_map_pkg::line_timer1_high);
   assign level_field_timer1_low = level_of(level_reg, irq_map_pkg::line_timer1_low);
   assign level_field_pulsegen1_low = level_of(level_reg, irq_map_pkg::line_pulsegen1_low);
   assign level_field_pulsegen1_high = level_of(level_reg, irq_map_pkg::line_pulsegen1_high);
   assign level_field_pulsegen0_high = level_of(level_reg, irq_map_pkg::line_pulsegen0_high);
   assign level_field_pulsegen0_low = level_of(level_reg, irq_map_pkg::line_pulsegen0_low);

   // per-source levels feed the picker through their own fields
   logic [47:0] pick_levels;
   always_comb begin
      pick_levels = level_reg;
      pick_levels[2*irq_map_pkg::line_timer0_low +: 2] = level_field_timer0_low; // [R1]
      pick_levels[2*irq_map_pkg::line_timer0_high +: 2] = level_field_timer0_high; // [R2]
      pick_levels[2*irq_map_pkg::line_timer1_high +: 2] = level_field_timer1_high; // [R3]
      pick_levels[2*irq_map_pkg::line_timer1_low +: 2] = level_field_timer1_low; // [R4]
      pick_levels[2*irq_map_pkg::line_pulsegen1_low +: 2] = level_field_pulsegen1_low; // [R5]
      pick_levels[2*irq_map_pkg::line_pulsegen1_high +: 2] = level_field_pulsegen1_high; // [R6]
      pick_levels[2*irq_map_pkg::line_pulsegen0_high +: 2] = level_field_pulsegen0_high; // [R7]
      pick_levels[2*irq_map_pkg::line_pulsegen0_low +: 2] = level_field_pulsegen0_low; // [R8]
   end

   // serial scan is the long path; the line, level and vector outputs wait on it, irq_out does not
   irq_priority_pick pick (
      .pend_in(lines),
      .level_in(pick_levels),
      .found_out(),
      .line_out(win_line),
      .level_out(win_level)
   );

   // a line may go to the cpu only when its level beats the cpu's own level
   for (genvar i = 0; i < irq_map_pkg::num_lines; i++) begin : g_eligible
      logic [1:0] line_level;
      assign line_level = level_of(pick_levels, 5'(i));
      assign eligible[i] = lines[i] && (line_level < cpu_level_reg); // [R11]
   end

   // raw lines, one cycle behind the sources, for the cpu's pending view
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         line_req_out <= 24'h00_0000;
      end else begin
         line_req_out <= lines;
      end
   end

   // level 0 is most urgent; a line at the cpu's own level is held off
   // parallel per-line compare keeps irq_out off the picker's serial scan
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |eligible; // [R11]
      end
   end

   // winner shown even when held off, so the cpu sees what is waiting
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_line_out <= 5'h00;
      end else begin
         irq_line_out <= win_line; // [R9]
      end
   end

   // idle reads as the least urgent level
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_level_out <= irq_map_pkg::level_reset;
      end else begin
         irq_level_out <= win_level;
      end
   end

   // vector pair follows the winner whether forwarded or not
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         vector_upper_addr_out <= 16'h0000;
      end else begin
         vector_upper_addr_out <= upper_addr(win_line); // [R11]
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         vector_lower_addr_out <= 16'h0000;
      end else begin
         vector_lower_addr_out <= lower_addr(win_line); // [R11]
      end
   end
endmodule // interrupt_vector_priority_map

// ===== irq_map_assertions.sv
`timescale 1ns/1ps
module irq_map_checker (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic irq_out,
   input wire logic timer0_low_req_in,
   input wire logic timer0_high_req_in,
   input wire logic timer1_high_req_in,
   input wire logic timer1_low_req_in,
   input wire logic pulsegen1_low_req_in,
   input wire logic pulsegen1_high_req_in,
   input wire logic pulsegen0_high_req_in,
   input wire logic pulsegen0_low_req_in,
   input wire logic [23:0] line_req_out,
   input wire logic [4:0] irq_line_out,
   input wire logic [1:0] irq_level_out,
   input wire logic [15:0] vector_upper_addr_out,
   input wire logic [15:0] vector_lower_addr_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_win; line_req_out[irq_line_out] ##0 irq_level_out != 2'h3; endsequence
   property p_t0l; timer0_low_req_in |=> line_req_out[5]; endproperty
   a_t0l: assert property (p_t0l) else $error("no line 5");
   property p_t0h; timer0_high_req_in |=> line_req_out[6]; endproperty
   a_t0h: assert property (p_t0h) else $error("no line 6");
   property p_t1h; timer1_high_req_in |=> line_req_out[14]; endproperty
   a_t1h: assert property (p_t1h) else $error("no line 14");
   property p_t1l; timer1_low_req_in |=> line_req_out[22]; endproperty
   a_t1l: assert property (p_t1l) else $error("no line 22");
   property p_pg1l; pulsegen1_low_req_in |=> line_req_out[9]; endproperty
   a_pg1l: assert property (p_pg1l) else $error("no line 9");
   property p_pg1h; pulsegen1_high_req_in |=> line_req_out[10]; endproperty
   a_pg1h: assert property (p_pg1h) else $error("no line 10");
   property p_pg0h; pulsegen0_high_req_in |=> line_req_out[12]; endproperty
   a_pg0h: assert property (p_pg0h) else $error("no line 12");
   property p_pg0l; pulsegen0_low_req_in |=> line_req_out[13]; endproperty
   a_pg0l: assert property (p_pg0l) else $error("no line 13");
   property p_idle; !(line_req_out[11] | line_req_out[17] | line_req_out[21]); endproperty
   a_idle: assert property (p_idle) else $error("unused line set");
   property p_win; irq_out |-> s_win; endproperty
   a_win: assert property (p_win) else $error("bad winner");
   property p_none; line_req_out == 24'h00_0000 |-> !irq_out; endproperty
   a_none: assert property (p_none) else $error("irq with no line");
   // reset values are no valid pair, so wait one edge
   property p_addr;
      $past(arst_n_in) |-> vector_upper_addr_out == 16'hFFFA - {10'h000, irq_line_out, 1'b0};
   endproperty
   a_addr: assert property (p_addr) else $error("bad vector");
   property p_pair;
      $past(arst_n_in) |-> vector_lower_addr_out == vector_upper_addr_out + 16'h0001;
   endproperty
   a_pair: assert property (p_pair) else $error("bad pair");
endmodule // irq_map_checker

bind interrupt_vector_priority_map irq_map_checker chk (.clk_in, .arst_n_in, .irq_out,
   .timer0_low_req_in, .timer0_high_req_in, .timer1_high_req_in, .timer1_low_req_in,
   .pulsegen1_low_req_in, .pulsegen1_high_req_in, .pulsegen0_high_req_in,
   .pulsegen0_low_req_in, .line_req_out, .irq_line_out, .irq_level_out,
   .vector_upper_addr_out, .vector_lower_addr_out);

// ===== irq_map_pkg.sv
package irq_map_pkg;
   localparam int unsigned num_lines = 24;
   localparam int unsigned num_ext = 8;
   localparam int unsigned num_per = 13;
   localparam int unsigned line_w = 5;
   // upper-byte vector address of line n; lower byte is the next address
   localparam logic [15:0] vector_base = 16'hFFFA;
   localparam logic [15:0] vector_step = 16'h0002;
   // level fields reset to lowest priority (3)
   localparam logic [1:0] level_reset = 2'h3;
   localparam logic [1:0] cpu_level_reset = 2'h3;
   // request lines of named sources and of the three unused lines
   localparam logic [4:0] line_uart_sio = 5'h04;
   localparam logic [4:0] line_timer0_low = 5'h05;
   localparam logic [4:0] line_timer0_high = 5'h06;
   localparam logic [4:0] line_lin_rx = 5'h07;
   localparam logic [4:0] line_lin_tx = 5'h08;
   localparam logic [4:0] line_pulsegen1_low = 5'h09;
   localparam logic [4:0] line_pulsegen1_high = 5'h0A;
   localparam logic [4:0] line_unused_a = 5'h0B;
   localparam logic [4:0] line_pulsegen0_high = 5'h0C;
   localparam logic [4:0] line_pulsegen0_low = 5'h0D;
   localparam logic [4:0] line_timer1_high = 5'h0E;
   localparam logic [4:0] line_pulse16 = 5'h0F;
   localparam logic [4:0] line_twowire = 5'h10;
   localparam logic [4:0] line_unused_b = 5'h11;
   localparam logic [4:0] line_converter = 5'h12;
   localparam logic [4:0] line_timebase = 5'h13;
   localparam logic [4:0] line_watch = 5'h14;
   localparam logic [4:0] line_unused_c = 5'h15;
   localparam logic [4:0] line_timer1_low = 5'h16;
   localparam logic [4:0] line_flash = 5'h17;
endpackage

// ===== irq_priority_pick.sv
`timescale 1ns/1ps
// fixed-order pick of the winning line among those at the best level
module irq_priority_pick (
   input wire logic [23:0] pend_in,
   input wire logic [47:0] level_in,
   output logic found_out,
   output logic [4:0] line_out,
   output logic [1:0] level_out
);
   always_comb begin
      found_out = 1'b0;
      line_out = 5'h00;
      level_out = 2'h3;
      // descending scan; the non-strict compare lets the lower index take ties
      for (int i = 23; i >= 0; i--) begin
         if (pend_in[i] && (!found_out || level_in[2*i +: 2] <= level_out)) begin // [R9]
            found_out = 1'b1;
            line_out = 5'(i);
            level_out = level_in[2*i +: 2];
         end
      end
   end
endmodule // irq_priority_pick

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_in, arst_n_in, irq;
   logic [23:0] rq, lro, e;
   logic [7:0] ext;
   logic [47:0] lf;
   logic [1:0] want, cl, lvl;
   logic [4:0] ln;
   logic [15:0] up, lo, fa;
   int fails = 0;
   int num_checks = 0;
   interrupt_vector_priority_map uut (.clk_in, .arst_n_in, .ext_req_in(ext),
      .uart_sio_req_in(rq[4]), .timer0_low_req_in(rq[5]), .timer0_high_req_in(rq[6]),
      .lin_rx_req_in(rq[7]), .lin_tx_req_in(rq[8]), .pulsegen1_low_req_in(rq[9]),
      .pulsegen1_high_req_in(rq[10]), .pulsegen0_high_req_in(rq[12]),
      .pulsegen0_low_req_in(rq[13]), .timer1_high_req_in(rq[14]), .pulse16_req_in(rq[15]),
      .twowire_req_in(rq[16]), .converter_req_in(rq[18]), .timebase_req_in(rq[19]),
      .watch_req_in(rq[20]), .timer1_low_req_in(rq[22]), .flash_req_in(rq[23]),
      .level_fields_in(lf), .cpu_level_in(cl), .line_req_out(lro), .irq_out(irq),
      .irq_line_out(ln), .irq_level_out(lvl), .vector_upper_addr_out(up),
      .vector_lower_addr_out(lo));
   cpu_model cpu (.clk_in, .irq_in(irq), .upper_in(up), .want_in(want), .level_out(cl),
      .fetch_out(fa));
   initial begin
      clk_in = 0;
      forever #10 clk_in = ~clk_in;
   end
   task chk(string s, logic [23:0] got, logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, got);
      end
   endtask
   // level changes need two cycles, so settle three
   task drive(logic [23:0] r, logic [7:0] x, logic [47:0] l, logic [1:0] c);
      @(posedge clk_in);
      rq <= r;
      ext <= x;
      lf <= l;
      want <= c;
      repeat (3) @(posedge clk_in);
      #1;
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      arst_n_in = 0;
      rq = 0;
      ext = 0;
      lf = 0;
      want = 2'h3;
      repeat (2) @(posedge clk_in);
      arst_n_in <= 1;
      repeat (2) @(posedge clk_in);
      #1;
      chk("idle level", lvl, 2'h3);
      chk("idle irq", irq, 0);
      // lines 0 to 3 are driven from the upper external channel
      for (int n = 0; n < 24; n++) begin
         drive(24'h00_0001 << n, n < 4 ? 8'h10 << n : 8'h00, 0, 2'h3);
         e = (n == 11 || n == 17 || n == 21) ? 24'h00_0000 : 24'h00_0001 << n;
         chk("lines", lro, e);
         chk("irq", irq, e != 0);
         if (e != 0) begin
            chk("line", ln, n);
            chk("level", lvl, 0);
            chk("fetch", fa, 16'hFFFA - 16'(2 * n));
            chk("lower", lo, 16'hFFFB - 16'(2 * n));
         end
      end
      // lines 0 to 3 again, now from the lower external channel
      for (int n = 0; n < 4; n++) begin
         drive(24'h00_0000, 8'h01 << n, 0, 2'h3);
         chk("lower channel", lro, 24'h00_0001 << n);
         chk("lower channel line", ln, n);
      end
      drive(24'hFF_FFFF, 8'hFF, {24{2'h2}}, 2'h3);
      chk("tie", ln, 0);
      chk("tie level", lvl, 2'h2);
      drive(24'hFF_FFFF, 8'hFF, {{18{2'h2}}, 2'h1, {5{2'h2}}}, 2'h3);
      chk("own level", ln, 5);
      chk("own vector", fa, 16'hFFF0);
      drive(24'hFF_FFFF, 8'hFF, {2'h2, 2'h1, {22{2'h2}}}, 2'h3);
      chk("level win", ln, 22);
      chk("vector", fa, 16'hFFCE);
      chk("vector lower", lo, 16'hFFCF);
      drive(24'hFF_FFFF, 8'hFF, {2'h2, 2'h1, {22{2'h2}}}, 2'h1);
      chk("refused", irq, 0);
      chk("winner held", ln, 22);
      drive(24'hFF_FFFF, 8'hFF, {2'h2, 2'h1, {22{2'h2}}}, 2'h2);
      chk("taken", irq, 1);
      summarize;
   end
   initial begin
      repeat (500) @(posedge clk_in);
      fails++;
      summarize;
   end
endmodule // testbench
